/* File: src/scl_regs.svh */
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH

// ==========================================================================
// Register byte addresses.
`define SCL_ADDR_MAIN      5'h00
`define SCL_ADDR_DEV       5'h01
`define SCL_ADDR_OSC       5'h02
`define SCL_ADDR_LOCK      5'h03
`define SCL_ADDR_MOD       5'h04
`define SCL_ADDR_R1        5'h06
`define SCL_ADDR_P1        5'h07
`define SCL_ADDR_S1        5'h08
`define SCL_ADDR_R2        5'h09
`define SCL_ADDR_P2        5'h0a
`define SCL_ADDR_S2        5'h0b

// ==========================================================================
// Field positions.
`define SCL_MODE_MSB       7
`define SCL_MODE_LSB       5
`define SCL_BAND_MSB       4
`define SCL_BAND_LSB       3
`define SCL_TRIM_MSB       2
`define SCL_TRIM_LSB       1
`define SCL_SETSEL_BIT     0
`define SCL_CLKEN_BIT      7
`define SCL_CLKDIV_MSB     6
`define SCL_CLKDIV_LSB     2
`define SCL_FLAG_BIT       1
`define SCL_PINEN_BIT      0
`define SCL_OOK_BIT        0

// ==========================================================================
// Reset values.
`define SCL_RST_MAIN       8'h20
`define SCL_RST_DEV        8'h03
`define SCL_RST_OSC        8'h80
`define SCL_RST_LOCK       8'h00
`define SCL_RST_MOD        8'h00
`define SCL_RST_R          8'h77
`define SCL_RST_P          8'h00
`define SCL_RST_S          8'h00

// ==========================================================================
// Mode codes, limits and centre shift codes.
`define SCL_MODE_SLEEP     3'h0
`define SCL_MODE_RX        3'h3
`define SCL_MODE_TX        3'h4
`define SCL_R_MIN          8'h40
`define SCL_R_MAX          8'ha9
`define SCL_BAND_BAD       2'h3
`define SCL_SHIFT_NONE     2'h0
`define SCL_SHIFT_DEV      2'h1
`define SCL_SHIFT_RX_IF    2'h2

`endif

/* File: src/scl_pkg.sv */
package scl_pkg;
   typedef logic [4:0] scl_addr_t;
   typedef logic [7:0] scl_byte_t;
   typedef enum logic [1:0] {
      HS_IDLE,
      HS_WRITE,
      HS_READ
   } scl_host_state_e;
endpackage

/* File: src/scl_cfg_if.sv */
`timescale 1ns/1ps
interface scl_cfg_if (
   input wire logic clk,
   input wire logic rst_n
);
   logic               wr;
   logic               rd;
   scl_pkg::scl_addr_t addr;
   scl_pkg::scl_byte_t wdata;
   scl_pkg::scl_byte_t rdata;
   logic               rvalid;

   modport dev (
      input  clk, rst_n, wr, rd, addr, wdata,
      output rdata, rvalid
   );
   modport host (
      input  clk, rst_n, rdata, rvalid,
      output wr, rd, addr, wdata
   );
endinterface

/* File: src/scl_synth_dev.sv */
`timescale 1ns/1ps
`include "scl_regs.svh"

module scl_synth_dev (
   // Clock and reset.
   input  wire logic       CLK_I,
   input  wire logic       RESET_N_I,
   // Configuration port.
   scl_cfg_if.dev          cfg,
   // Synthesizer lock level from the analog loop.
   input  wire logic       SYNTH_LOCK_I,
   // Clock and lock pins.
   output logic            REF_CLK_O,
   output logic            LOCK_PIN_O,
   // Synthesizer settings.
   output logic [7:0]      DIV_R_O,
   output logic [7:0]      DIV_P_O,
   output logic [7:0]      DIV_S_O,
   output logic [1:0]      BAND_O,
   output logic [1:0]      TRIM_O,
   output logic [7:0]      DEV_O,
   output logic [1:0]      SHIFT_O,
   // Operating state.
   output logic            TX_ON_O,
   output logic            RX_ON_O,
   output logic            OOK_O,
   output logic            SLEEP_O
);

   // ==========================================================================
   // Write decode.
   logic       wr_main;
   logic       wr_dev;
   logic       wr_osc;
   logic       wr_lock;
   logic       wr_mod;
   logic       clr_flag;

   assign wr_main  = cfg.wr && (cfg.addr == `SCL_ADDR_MAIN);
   assign wr_dev   = cfg.wr && (cfg.addr == `SCL_ADDR_DEV);
   assign wr_osc   = cfg.wr && (cfg.addr == `SCL_ADDR_OSC);
   assign wr_lock  = cfg.wr && (cfg.addr == `SCL_ADDR_LOCK);
   assign wr_mod   = cfg.wr && (cfg.addr == `SCL_ADDR_MOD);
   assign clr_flag = wr_lock && cfg.wdata[`SCL_FLAG_BIT];

   // ==========================================================================
   // Configuration registers.
   logic [7:0] main_q;
   logic [7:0] dev_q;
   logic [7:0] osc_q;
   logic       pin_en_q;
   logic       ook_q;

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         main_q   <= `SCL_RST_MAIN;
         dev_q    <= `SCL_RST_DEV;
         osc_q    <= `SCL_RST_OSC;
         pin_en_q <= 1'(`SCL_RST_LOCK);
         ook_q    <= 1'(`SCL_RST_MOD);
      end else begin
         if (wr_main) begin
            main_q <= cfg.wdata;
         end
         if (wr_dev) begin
            dev_q <= cfg.wdata;
         end
         if (wr_osc) begin
            osc_q <= cfg.wdata;
         end
         if (wr_lock) begin
            pin_en_q <= cfg.wdata[`SCL_PINEN_BIT];
         end
         if (wr_mod) begin
            ook_q <= cfg.wdata[`SCL_OOK_BIT];
         end
      end
   end

   // ==========================================================================
   // Divider bytes, two complete sets.
   logic [7:0] div_q [0:5];

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_div
         logic       wr_this;
         logic [7:0] rst_val;
         assign wr_this = cfg.wr && (cfg.addr == (`SCL_ADDR_R1 + 5'(gi)));
         assign rst_val = ((gi % 3) == 0) ? `SCL_RST_R :
                          ((gi % 3) == 1) ? `SCL_RST_P : `SCL_RST_S;
         always_ff @(posedge CLK_I) begin
            if (!RESET_N_I) begin
               div_q[gi] <= `SCL_RST_R;
               if ((gi % 3) != 0) begin
                  div_q[gi] <= rst_val;
               end
            end else if (wr_this) begin
               div_q[gi] <= cfg.wdata;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Mode and divider selection.
   logic [2:0] mode;
   logic       set_sel;
   logic       is_tx;
   logic       is_rx;
   logic       is_sleep;
   logic [7:0] sel_r;
   logic [7:0] sel_p;
   logic [7:0] sel_s;
   logic [1:0] shift_d;

   assign mode     = main_q[`SCL_MODE_MSB:`SCL_MODE_LSB];
   assign set_sel  = main_q[`SCL_SETSEL_BIT];
   assign is_tx    = (mode == `SCL_MODE_TX);
   assign is_rx    = (mode == `SCL_MODE_RX);
   assign is_sleep = (mode == `SCL_MODE_SLEEP);
   // Both sets stay stored, so switching is a single select change.
   assign sel_r    = set_sel ? div_q[3] : div_q[0];
   assign sel_p    = set_sel ? div_q[4] : div_q[1];
   assign sel_s    = set_sel ? div_q[5] : div_q[2];
   assign shift_d  = !ook_q ? `SCL_SHIFT_NONE :
                     is_tx  ? `SCL_SHIFT_DEV :
                     is_rx  ? `SCL_SHIFT_RX_IF : `SCL_SHIFT_NONE;

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         DIV_R_O <= `SCL_RST_R;
         DIV_P_O <= `SCL_RST_P;
         DIV_S_O <= `SCL_RST_S;
         BAND_O  <= 2'(`SCL_RST_MAIN >> `SCL_BAND_LSB);
         TRIM_O  <= 2'h0;
         DEV_O   <= `SCL_RST_DEV;
         SHIFT_O <= `SCL_SHIFT_NONE;
         TX_ON_O <= 1'b0;
         RX_ON_O <= 1'b0;
         OOK_O   <= 1'b0;
         SLEEP_O <= 1'b0;
      end else begin
         // All three dividers move on the same edge, never a mixed set.
         DIV_R_O <= sel_r;
         DIV_P_O <= sel_p;
         DIV_S_O <= sel_s;
         BAND_O  <= main_q[`SCL_BAND_MSB:`SCL_BAND_LSB];
         TRIM_O  <= main_q[`SCL_TRIM_MSB:`SCL_TRIM_LSB];
         DEV_O   <= dev_q;
         SHIFT_O <= shift_d;
         TX_ON_O <= is_tx;
         RX_ON_O <= is_rx;
         OOK_O   <= ook_q;
         SLEEP_O <= is_sleep;
      end
   end

   // ==========================================================================
   // Reference clock output divider.
   logic [4:0] clk_cnt_q;
   logic       clk_run;
   logic [4:0] clk_div;

   assign clk_div = osc_q[`SCL_CLKDIV_MSB:`SCL_CLKDIV_LSB];
   assign clk_run = osc_q[`SCL_CLKEN_BIT] && !is_sleep;

   // The output is a registered toggle, so the fastest rate is half the
   // reference; this keeps the pin glitch free on ratio changes.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         clk_cnt_q <= 5'h00;
         REF_CLK_O <= 1'b0;
      end else if (!clk_run) begin
         clk_cnt_q <= 5'h00;
         REF_CLK_O <= 1'b0;
      end else if (clk_cnt_q >= clk_div) begin
         clk_cnt_q <= 5'h00;
         REF_CLK_O <= !REF_CLK_O;
      end else begin
         clk_cnt_q <= clk_cnt_q + 5'h01;
      end
   end

   // ==========================================================================
   // Lock detection.
   logic       lock_s1_q;
   logic       lock_s2_q;
   logic       flag_q;

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         lock_s1_q  <= 1'b0;
         lock_s2_q  <= 1'b0;
         flag_q     <= 1'b0;
         LOCK_PIN_O <= 1'b0;
      end else begin
         lock_s1_q  <= SYNTH_LOCK_I;
         lock_s2_q  <= lock_s1_q;
         // A lock seen in the clearing cycle keeps the flag set.
         flag_q     <= lock_s2_q || (flag_q && !clr_flag);
         LOCK_PIN_O <= pin_en_q && flag_q;
      end
   end

   // ==========================================================================
   // Read back.
   logic [7:0] rd_word;

   always_comb begin
      rd_word = 8'h00;
      if (cfg.addr == `SCL_ADDR_MAIN) begin
         rd_word = main_q;
      end else if (cfg.addr == `SCL_ADDR_DEV) begin
         rd_word = dev_q;
      end else if (cfg.addr == `SCL_ADDR_OSC) begin
         rd_word = osc_q;
      end else if (cfg.addr == `SCL_ADDR_LOCK) begin
         rd_word = {6'h00, flag_q, pin_en_q};
      end else if (cfg.addr == `SCL_ADDR_MOD) begin
         rd_word = {7'h00, ook_q};
      end else if ((cfg.addr >= `SCL_ADDR_R1) && (cfg.addr <= `SCL_ADDR_S2)) begin
         rd_word = div_q[3'(cfg.addr - `SCL_ADDR_R1)];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         cfg.rdata  <= 8'h00;
         cfg.rvalid <= 1'b0;
      end else begin
         cfg.rvalid <= cfg.rd;
         if (cfg.rd) begin
            cfg.rdata <= rd_word;
         end
      end
   end

endmodule

/* File: src/scl_synth_host.sv */
`timescale 1ns/1ps
`include "scl_regs.svh"

module scl_synth_host (
   // Clock and reset.
   input  wire logic                CLK_I,
   input  wire logic                RESET_N_I,
   // Configuration port toward the device.
   scl_cfg_if.host                  cfg,
   // Command side.
   input  wire logic                CMD_VALID_I,
   input  wire logic                CMD_WRITE_I,
   input  wire scl_pkg::scl_addr_t  CMD_ADDR_I,
   input  wire scl_pkg::scl_byte_t  CMD_WDATA_I,
   output logic                     CMD_READY_O,
   // Response side.
   output logic                     RSP_VALID_O,
   output logic                     RSP_ERR_O,
   output scl_pkg::scl_byte_t       RSP_DATA_O
);

   // ==========================================================================
   // Legality checks on writes.
   scl_pkg::scl_host_state_e state_q;
   logic [7:0] p_sh_q [0:1];
   logic       take;
   logic       is_r;
   logic       is_p;
   logic       is_s;
   logic       set2;
   logic       r_bad;
   logic       s_bad;
   logic       band_bad;
   logic       wr_bad;

   assign take     = CMD_VALID_I && CMD_READY_O;
   assign set2     = (CMD_ADDR_I >= `SCL_ADDR_R2);
   assign is_r     = (CMD_ADDR_I == `SCL_ADDR_R1) || (CMD_ADDR_I == `SCL_ADDR_R2);
   assign is_p     = (CMD_ADDR_I == `SCL_ADDR_P1) || (CMD_ADDR_I == `SCL_ADDR_P2);
   assign is_s     = (CMD_ADDR_I == `SCL_ADDR_S1) || (CMD_ADDR_I == `SCL_ADDR_S2);
   assign r_bad    = is_r && ((CMD_WDATA_I < `SCL_R_MIN) || (CMD_WDATA_I > `SCL_R_MAX));
   assign s_bad    = is_s && (CMD_WDATA_I > p_sh_q[set2]);
   assign band_bad = (CMD_ADDR_I == `SCL_ADDR_MAIN) &&
                     (CMD_WDATA_I[`SCL_BAND_MSB:`SCL_BAND_LSB] == `SCL_BAND_BAD);
   assign wr_bad   = CMD_WRITE_I && (r_bad || s_bad || band_bad);

   // ==========================================================================
   // Transfer sequencer.
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state_q     <= scl_pkg::HS_IDLE;
         p_sh_q[0]   <= `SCL_RST_P;
         p_sh_q[1]   <= `SCL_RST_P;
         cfg.wr      <= 1'b0;
         cfg.rd      <= 1'b0;
         cfg.addr    <= 5'h00;
         cfg.wdata   <= 8'h00;
         CMD_READY_O <= 1'b0;
         RSP_VALID_O <= 1'b0;
         RSP_ERR_O   <= 1'b0;
         RSP_DATA_O  <= 8'h00;
      end else begin
         RSP_VALID_O <= 1'b0;
         cfg.wr      <= 1'b0;
         cfg.rd      <= 1'b0;
         case (state_q)
            scl_pkg::HS_IDLE: begin
               CMD_READY_O <= 1'b1;
               if (take && wr_bad) begin
                  // Refused writes never reach the device.
                  RSP_VALID_O <= 1'b1;
                  RSP_ERR_O   <= 1'b1;
                  RSP_DATA_O  <= 8'h00;
               end else if (take) begin
                  CMD_READY_O <= 1'b0;
                  cfg.addr    <= CMD_ADDR_I;
                  cfg.wdata   <= CMD_WDATA_I;
                  cfg.wr      <= CMD_WRITE_I;
                  cfg.rd      <= !CMD_WRITE_I;
                  state_q     <= CMD_WRITE_I ? scl_pkg::HS_WRITE : scl_pkg::HS_READ;
                  if (CMD_WRITE_I && is_p) begin
                     p_sh_q[set2] <= CMD_WDATA_I;
                  end
               end
            end
            scl_pkg::HS_WRITE: begin
               RSP_VALID_O <= 1'b1;
               RSP_ERR_O   <= 1'b0;
               RSP_DATA_O  <= 8'h00;
               CMD_READY_O <= 1'b1;
               state_q     <= scl_pkg::HS_IDLE;
            end
            scl_pkg::HS_READ: begin
               if (cfg.rvalid) begin
                  RSP_VALID_O <= 1'b1;
                  RSP_ERR_O   <= 1'b0;
                  RSP_DATA_O  <= cfg.rdata;
                  CMD_READY_O <= 1'b1;
                  state_q     <= scl_pkg::HS_IDLE;
               end
            end
            default: begin
               state_q <= scl_pkg::HS_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: bench/scl_cfg_monitor.sv */
`timescale 1ns/1ps

// ===========================================================================
// Checker on the configuration link between the host and the device.
module scl_cfg_monitor (
   // Clock and reset.
   input wire logic               clk,
   input wire logic               rst_n,
   // Link signals.
   input wire logic               wr,
   input wire logic               rd,
   input wire scl_pkg::scl_addr_t addr,
   input wire scl_pkg::scl_byte_t wdata,
   input wire scl_pkg::scl_byte_t rdata,
   input wire logic               rvalid
);
   wire unmapped = (addr == 5'h05) || (addr >= 5'h0c);
   wire r_addr   = (addr == 5'h06) || (addr == 5'h09);

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_read; rd ##1 rvalid; endsequence
   sequence s_wr_pulse; wr ##1 !wr; endsequence

   property p_read_answer; rd |-> s_read; endproperty
   property p_no_stray_valid; !rd |=> !rvalid; endproperty
   property p_wr_pulse; wr |-> s_wr_pulse; endproperty
   property p_rd_pulse; rd |=> !rd; endproperty
   property p_unmapped_zero; rd && unmapped |=> rdata == 8'h00; endproperty
   property p_lock_reserved; rd && addr == 5'h03 |=> rdata[7:2] == 6'h00; endproperty
   property p_mod_reserved; rd && addr == 5'h04 |=> rdata[7:1] == 7'h00; endproperty
   property p_r_range; wr && r_addr |-> wdata >= 8'h40 && wdata <= 8'ha9; endproperty
   property p_band_legal; wr && addr == 5'h00 |-> wdata[4:3] != 2'h3; endproperty
   property p_rdata_hold; !rd |=> $stable(rdata); endproperty

   a_read_answer: assert property (p_read_answer)
      else $error("read without answer");
   a_no_stray_valid: assert property (p_no_stray_valid)
      else $error("read valid without read");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe longer than one cycle");
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   a_lock_reserved: assert property (p_lock_reserved)
      else $error("lock byte reserved bits set");
   a_mod_reserved: assert property (p_mod_reserved)
      else $error("modulation byte reserved bits set");
   a_r_range: assert property (p_r_range)
      else $error("reference divider out of range sent");
   a_band_legal: assert property (p_band_legal)
      else $error("illegal band code sent");
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without read");
endmodule

/* File: bench/synth_config_and_lock_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "scl_regs.svh"

`define CHK(act, exp) begin \
   num_checks++; \
   if ((act) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
   end \
end

module synth_config_and_lock_ctrl_tb_top;
   typedef struct packed {
      logic               rd;
      logic               err;
      scl_pkg::scl_byte_t data;
   } scl_exp_s;

   logic               clk = 1'b0;
   logic               rst_n, lock_in, cmd_valid, cmd_write, cmd_ready;
   logic               rsp_valid, rsp_err, ref_clk, lock_pin, tx_on, rx_on, ook, sleep;
   scl_pkg::scl_addr_t cmd_addr;
   scl_pkg::scl_byte_t cmd_wdata, rsp_data, div_r, div_p, div_s, dev;
   logic [1:0]         band, trim, shift;
   int                 n_mismatch = 0;
   int                 num_checks = 0;
   scl_exp_s           exp_q[$];
   scl_exp_s           e;
   scl_pkg::scl_addr_t ra[14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07,
                                  5'h08, 5'h09, 5'h0a, 5'h0b, 5'h05, 5'h0c, 5'h1f};
   scl_pkg::scl_byte_t rv[14] = '{`SCL_RST_MAIN, `SCL_RST_DEV, `SCL_RST_OSC, `SCL_RST_LOCK,
                                  `SCL_RST_MOD, `SCL_RST_R, `SCL_RST_P, `SCL_RST_S,
                                  `SCL_RST_R, `SCL_RST_P, `SCL_RST_S, 8'h00, 8'h00, 8'h00};

   always #5 clk = ~clk;

   // ========================================================================
   // The two ends joined by the link.
   scl_cfg_if cfg_bus (.clk(clk), .rst_n(rst_n));
   scl_synth_host u_scl_synth_host (.CLK_I(clk), .RESET_N_I(rst_n), .cfg(cfg_bus),
      .CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr),
      .CMD_WDATA_I(cmd_wdata), .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid),
      .RSP_ERR_O(rsp_err), .RSP_DATA_O(rsp_data));
   scl_synth_dev u_scl_synth_dev (.CLK_I(clk), .RESET_N_I(rst_n), .cfg(cfg_bus),
      .SYNTH_LOCK_I(lock_in), .REF_CLK_O(ref_clk), .LOCK_PIN_O(lock_pin), .DIV_R_O(div_r),
      .DIV_P_O(div_p), .DIV_S_O(div_s), .BAND_O(band), .TRIM_O(trim), .DEV_O(dev),
      .SHIFT_O(shift), .TX_ON_O(tx_on), .RX_ON_O(rx_on), .OOK_O(ook), .SLEEP_O(sleep));
   scl_cfg_monitor u_mon (.clk(cfg_bus.clk), .rst_n(cfg_bus.rst_n), .wr(cfg_bus.wr),
      .rd(cfg_bus.rd), .addr(cfg_bus.addr), .wdata(cfg_bus.wdata),
      .rdata(cfg_bus.rdata), .rvalid(cfg_bus.rvalid));

   // ========================================================================
   // Drivers and helpers.
   task tick; @(posedge clk); #1; endtask

   task cmd(input logic w, input scl_pkg::scl_addr_t a, input scl_pkg::scl_byte_t d,
            input logic err);
      int n;
      tick;
      cmd_valid = 1'b1; cmd_write = w; cmd_addr = a; cmd_wdata = d;
      for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) tick;
      if (cmd_ready !== 1'b1) n_mismatch++;
      exp_q.push_back('{!w, err, d});
      tick;
      cmd_valid = 1'b0;
   endtask

   task wr(input scl_pkg::scl_addr_t a, input scl_pkg::scl_byte_t d, input logic err = 1'b0);
      cmd(1'b1, a, d, err);
   endtask

   task rd(input scl_pkg::scl_addr_t a, input scl_pkg::scl_byte_t d);
      cmd(1'b0, a, d, 1'b0);
   endtask

   // Output flops follow the register one edge late, hence the extra ticks.
   task drain;
      int n;
      for (n = 0; n < 50 && exp_q.size() != 0; n++) tick;
      if (exp_q.size() != 0) n_mismatch++;
      repeat (3) tick;
   endtask

   task half(output int n);
      int k;
      n = 0;
      for (k = 0; k < 80 && ref_clk !== 1'b0; k++) tick;
      for (k = 0; k < 80 && ref_clk !== 1'b1; k++) tick;
      while (ref_clk === 1'b1 && n < 80) begin tick; n++; end
   endtask

   // ========================================================================
   // Response checker against the noted expectations.
   always @(posedge clk) begin
      #2;
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(rsp_valid, 1'b0)
         end else begin
            e = exp_q.pop_front();
            `CHK(rsp_err, e.err)
            if (e.rd) `CHK(rsp_data, e.data)
         end
      end
   end

   task test_done;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #100us;
      n_mismatch++;
      test_done;
   end

   // ========================================================================
   // Main sequence.
   initial begin
      int m, n, k, dummy;
      scl_pkg::scl_byte_t r, cur_r, dv;
      rst_n = 1'b0; lock_in = 1'b0; cmd_valid = 1'b0; cmd_write = 1'b0;
      cmd_addr = '0; cmd_wdata = '0;
      dummy = $urandom(21480);
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      tick;
      half(n); `CHK(n, 1)
      `CHK(trim, 2'h0)
      `CHK(shift, `SCL_SHIFT_NONE)
      for (k = 0; k < 14; k++) rd(ra[k], rv[k]);
      drain;
      // Divide ratios at both ends of the field, then the clock stopped.
      for (k = 0; k < 3; k++) begin
         m = (k == 0) ? 0 : (k == 1) ? 3 : 31;
         wr(5'h02, {1'b1, 5'(m), 2'h0}); drain;
         half(n); `CHK(n, m + 1)
      end
      wr(5'h02, 8'h00); drain;
      repeat (4) begin tick; `CHK(ref_clk, 1'b0) end
      wr(5'h02, 8'h80);
      // Random reference dividers, refused outside the legal span.
      cur_r = `SCL_RST_R;
      for (k = 0; k < 8; k++) begin
         r = 8'($urandom_range(0, 255));
         if (k == 0) r = 8'h3f;
         if (k == 1) r = 8'haa;
         if (k == 2) r = 8'h40;
         if (k == 3) r = 8'h77;
         wr(5'h06, r, (r < 8'h40) || (r > 8'ha9));
         if (r >= 8'h40 && r <= 8'ha9) cur_r = r;
      end
      rd(5'h06, cur_r);
      wr(5'h07, 8'h05); wr(5'h08, 8'h05); wr(5'h08, 8'h06, 1'b1);
      wr(5'h09, 8'ha9); wr(5'h0a, 8'h10); wr(5'h0b, 8'h11, 1'b1); wr(5'h0b, 8'h03);
      wr(5'h00, 8'h38, 1'b1); drain;
      `CHK({div_r, div_p, div_s}, {cur_r, 8'h05, 8'h05})
      wr(5'h00, 8'h21); drain;
      `CHK({div_r, div_p, div_s}, {8'ha9, 8'h10, 8'h03})
      dv = 8'($urandom);
      wr(5'h01, dv); wr(5'h04, 8'h01); drain;
      `CHK(dev, dv)
      `CHK(ook, 1'b1)
      // Every mode code with band and trim stepping alongside.
      for (m = 0; m < 8; m++) begin
         wr(5'h00, {m[2:0], 2'(m % 3), m[1:0], 1'b0}); drain;
         `CHK(tx_on, 1'(m == 4))
         `CHK(rx_on, 1'(m == 3))
         `CHK(sleep, 1'(m == 0))
         `CHK(shift, (m == 4) ? `SCL_SHIFT_DEV : (m == 3) ? `SCL_SHIFT_RX_IF : 2'h0)
         `CHK({band, trim}, {2'(m % 3), m[1:0]})
         if (m == 0) repeat (4) begin tick; `CHK(ref_clk, 1'b0) end
      end
      // Transmit with OOK off keeps the carrier unshifted.
      wr(5'h04, 8'h00); wr(5'h00, 8'h80); drain;
      `CHK({tx_on, ook, shift}, {2'b10, `SCL_SHIFT_NONE})
      wr(5'h00, 8'h20); drain;
      `CHK(div_r, cur_r)
      // Lock flag, pin mirror and clear by writing one.
      lock_in = 1'b1;
      repeat (6) tick;
      rd(5'h03, 8'h02); drain;
      `CHK(lock_pin, 1'b0)
      wr(5'h03, 8'h01); drain;
      `CHK(lock_pin, 1'b1)
      lock_in = 1'b0;
      repeat (4) tick;
      wr(5'h03, 8'h03); rd(5'h03, 8'h01); drain;
      `CHK(lock_pin, 1'b0)
      test_done;
   end
endmodule
